// >>> rtl/tma_pkg.sv
package tma_pkg;
  // Register selection values.
  localparam logic [1:0] TMA_SEL_RESULT = 2'h0;
  localparam logic [1:0] TMA_SEL_SETTINGS = 2'h1;
  localparam logic [1:0] TMA_SEL_RELEASE = 2'h2;
  localparam logic [1:0] TMA_SEL_TRIP = 2'h3;
  // Reset values.
  localparam logic [7:0] TMA_SETTINGS_RST = 8'h00;
  localparam logic [15:0] TMA_RELEASE_RST = 16'h4B00;
  localparam logic [15:0] TMA_TRIP_RST = 16'h5000;
  localparam logic [1:0] TMA_SEL_RST = 2'h0;
  // Settings field positions.
  localparam int TMA_BIT_SHUTDOWN = 0;
  localparam int TMA_BIT_STYLE = 1;
  localparam int TMA_BIT_POL = 2;
  localparam int TMA_BIT_FQ_LO = 3;
  // Fixed upper part of the slave address.
  localparam logic [3:0] TMA_ADDR_FIXED = 4'h9;
  // Timing.
  localparam int TMA_CLK_HZ = 100_000_000;
  localparam int TMA_PERIOD_MS = 100;
  localparam int TMA_CONV_MS = 10;
  localparam int TMA_STUCK_MS = 50;
  localparam int TMA_PERIOD_CYC = TMA_CLK_HZ / 1000 * TMA_PERIOD_MS;
  localparam int TMA_CONV_CYC = TMA_CLK_HZ / 1000 * TMA_CONV_MS;
  localparam int TMA_STUCK_CYC = TMA_CLK_HZ / 1000 * TMA_STUCK_MS;

  typedef struct packed {
    logic [1:0] fault_count_select;
    logic alarm_polarity;
    logic alarm_style_select;
    logic shutdown;
  } tma_settings_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic scl;
    logic sda;
  } tma_line_t;
endpackage : tma_pkg

// >>> rtl/tma_sync.sv
`timescale 1ns/10ps
`default_nettype none
// Two-flop synchroniser for one pin.
module tma_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pin and result
  input wire logic pin,
  output logic sync
);
  logic meta;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta <= 1'b1;
      sync <= 1'b1;
    end else begin
      meta <= pin;
      sync <= meta;
    end
  end
endmodule : tma_sync
`default_nettype wire

// >>> rtl/tma_converter.sv
`timescale 1ns/10ps
`default_nettype none
// Conversion scheduler: busy for the conversion time, then idle to the
// end of the period. The sample is captured when busy ends.
module tma_converter #(
  parameter int PERIOD_CYC = tma_pkg::TMA_PERIOD_CYC,
  parameter int CONV_CYC = tma_pkg::TMA_CONV_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic [10:0] sample,
  // Result
  output logic busy,
  output logic done,
  output logic [10:0] result
);
  import tma_pkg::*;
  logic [31:0] cnt;
  logic run_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt <= 32'h0;
      run_q <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      result <= 11'h000;
    end else begin
      run_q <= run;
      done <= 1'b0;
      if (!run) begin
        busy <= 1'b0;
        cnt <= 32'h0;
      end else if (!run_q || cnt == 32'(PERIOD_CYC - 1)) begin
        // Start right away when entering normal mode, and every period.
        busy <= 1'b1;
        cnt <= 32'h0;
      end else begin
        cnt <= cnt + 32'h1;
        if (busy && cnt == 32'(CONV_CYC - 1)) begin
          busy <= 1'b0;
          done <= 1'b1;
          result <= sample;
        end
      end
    end
  end
endmodule : tma_converter
`default_nettype wire

// >>> rtl/tma_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module tma_monitor #(
  parameter int PERIOD_CYC = tma_pkg::TMA_PERIOD_CYC,
  parameter int CONV_CYC = tma_pkg::TMA_CONV_CYC,
  parameter int STUCK_CYC = tma_pkg::TMA_STUCK_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address straps
  input wire logic addr_strap_hi,
  input wire logic addr_strap_mid,
  input wire logic addr_strap_lo,
  // Sensor front end
  input wire logic [10:0] sensor_sample,
  output logic converter_busy,
  // Alarm pin, open drain
  output logic alarm_output,
  output logic alarm_oe
);
  import tma_pkg::*;

  typedef enum logic [2:0] {
    TMA_IDLE = 3'b000,
    TMA_ADDR = 3'b001,
    TMA_ACK = 3'b011,
    TMA_RX = 3'b010,
    TMA_TX = 3'b110,
    TMA_MACK = 3'b111,
    TMA_SKIP = 3'b101
  } tma_state_t;

  tma_settings_t settings;
  logic [15:0] release_threshold;
  logic [15:0] trip_threshold;
  logic [15:0] temperature_result;
  logic [1:0] sel;
  logic [10:0] conv_result;
  logic conv_done;
  logic scl_s, sda_s, scl_q, sda_q;
  tma_line_t line;
  tma_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [1:0] bytecnt;
  logic is_read;
  logic [15:0] txword;
  logic [6:0] my_addr;
  logic [31:0] stuck_cnt;
  logic stuck;
  logic reg_read;
  logic alarm;
  logic want_release;
  logic [2:0] fault_cnt;
  logic [2:0] need;
  logic shut_q;
  logic [7:0] rx_byte;
  logic rx_stb;
  logic [2:0] strap_meta;
  logic signed [8:0] t9;
  logic fault;
  logic event_hit;
  logic clear_hit;

  tma_sync u_scl (.sys_clk(sys_clk), .rst(rst), .pin(scl_in), .sync(scl_s));
  tma_sync u_sda (.sys_clk(sys_clk), .rst(rst), .pin(sda_in), .sync(sda_s));

  // The converter runs on its own schedule; bus traffic touches it only through the shutdown setting.
  tma_converter #(.PERIOD_CYC(PERIOD_CYC), .CONV_CYC(CONV_CYC)) u_conv (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(!settings.shutdown),
    .sample(sensor_sample),
    .busy(converter_busy),
    .done(conv_done),
    .result(conv_result)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  always_comb begin
    line.scl = scl_s;
    line.sda = sda_s;
    line.start = scl_s && scl_q && sda_q && !sda_s;
    line.stop = scl_s && scl_q && !sda_q && sda_s;
  end

  // Straps are pins: two flops stand before the address compare.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strap_meta <= 3'b000;
      my_addr <= {TMA_ADDR_FIXED, 3'b000};
    end else begin
      strap_meta <= {addr_strap_hi, addr_strap_mid, addr_strap_lo};
      my_addr <= {TMA_ADDR_FIXED, strap_meta};
    end
  end

  // Bus-stuck watchdog on the data line.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stuck_cnt <= 32'h0;
      stuck <= 1'b0;
    end else begin
      stuck <= 1'b0;
      if (line.sda) begin
        stuck_cnt <= 32'h0;
      end else if (stuck_cnt == 32'(STUCK_CYC - 1)) begin
        stuck <= 1'b1;
        stuck_cnt <= 32'h0;
      end else begin
        stuck_cnt <= stuck_cnt + 32'h1;
      end
    end
  end

  always_comb begin
    case (sel)
      TMA_SEL_RESULT: txword = temperature_result;
      TMA_SEL_SETTINGS: txword = {3'b000, settings, 8'h00};
      TMA_SEL_RELEASE: txword = release_threshold;
      default: txword = trip_threshold;
    endcase
  end

  // Slave state machine; bits sampled on SCL rise, driven after SCL fall.
  always_ff @(posedge sys_clk) begin
    if (rst || stuck || line.start || line.stop) begin
      state <= (line.start && !rst && !stuck) ? TMA_ADDR : TMA_IDLE;
      bitcnt <= 4'h0;
      bytecnt <= 2'h0;
      shreg <= 8'h00;
      is_read <= 1'b0;
      sda_oe <= 1'b0;
      rx_stb <= 1'b0;
      rx_byte <= 8'h00;
      reg_read <= 1'b0;
    end else begin
      rx_stb <= 1'b0;
      reg_read <= 1'b0;
      if (line.scl && !scl_q) begin
        case (state)
          TMA_ADDR, TMA_RX: begin
            shreg <= {shreg[6:0], line.sda};
            bitcnt <= bitcnt + 4'h1;
          end
          TMA_MACK: begin
            state <= line.sda ? TMA_SKIP : TMA_TX;
          end
          default: begin
          end
        endcase
      end else if (!line.scl && scl_q) begin
        case (state)
          TMA_ADDR: begin
            if (bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              if (shreg[7:1] == my_addr) begin
                is_read <= shreg[0];
                state <= TMA_ACK;
                sda_oe <= 1'b1;
              end else begin
                state <= TMA_SKIP;
              end
            end
          end
          TMA_RX: begin
            if (bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              rx_byte <= shreg;
              // Written bytes are counted so the select byte stays apart.
              if (bytecnt != 2'h3) bytecnt <= bytecnt + 2'h1;
              rx_stb <= 1'b1;
              state <= TMA_ACK;
              sda_oe <= 1'b1;
            end
          end
          TMA_ACK: begin
            if (is_read) begin
              state <= TMA_TX;
              reg_read <= 1'b1;
              sda_oe <= !txword[15];
              shreg <= txword[14:7];
              bitcnt <= 4'h1;
            end else begin
              state <= TMA_RX;
              sda_oe <= 1'b0;
            end
          end
          TMA_TX: begin
            if (bitcnt == 4'h8) begin
              state <= TMA_MACK;
              sda_oe <= 1'b0;
              bytecnt <= bytecnt + 2'h1;
              bitcnt <= 4'h0;
            end else begin
              sda_oe <= !shreg[7];
              shreg <= {shreg[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
            end
          end
          TMA_MACK: begin
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
        if (state == TMA_MACK) begin
          sda_oe <= 1'b0;
        end
      end
      // Second byte of the word, then the word repeats.
      if (state == TMA_MACK && line.scl && !scl_q && !line.sda) begin
        shreg <= bytecnt[0] ? txword[7:0] : txword[15:8];
        bitcnt <= 4'h0;
      end
    end
  end

  assign sda_out = 1'b0;

  // Register writes: first byte selects, then high byte, then low byte.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      settings <= tma_settings_t'(TMA_SETTINGS_RST[4:0]);
      release_threshold <= TMA_RELEASE_RST;
      trip_threshold <= TMA_TRIP_RST;
      sel <= TMA_SEL_RST;
    end else if (rx_stb) begin
      if (bytecnt == 2'h1) begin
        sel <= rx_byte[1:0];
      end else if (sel == TMA_SEL_SETTINGS) begin
        if (bytecnt == 2'h2) begin
          settings <= tma_settings_t'(rx_byte[4:0]);
        end
      end else if (sel == TMA_SEL_RELEASE) begin
        if (bytecnt == 2'h2) release_threshold[15:8] <= rx_byte;
        else release_threshold[7:0] <= rx_byte & 8'h80;
      end else if (sel == TMA_SEL_TRIP) begin
        if (bytecnt == 2'h2) trip_threshold[15:8] <= rx_byte;
        else trip_threshold[7:0] <= rx_byte & 8'h80;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      temperature_result <= 16'h0000;
    end else if (conv_done) begin
      temperature_result <= {conv_result, 5'b00000};
    end
  end

  always_comb begin
    case (settings.fault_count_select)
      2'h0: need = 3'd1;
      2'h1: need = 3'd2;
      2'h2: need = 3'd4;
      default: need = 3'd6;
    endcase
  end

  // Alarm decision at the end of each normal-mode conversion.
  always_comb begin
    t9 = signed'(conv_result[10:2]);
    if (want_release) begin
      fault = t9 < signed'(release_threshold[15:7]);
    end else begin
      fault = t9 > signed'(trip_threshold[15:7]);
    end
    event_hit = conv_done && fault && (fault_cnt + 3'h1 >= need);
    clear_hit = settings.alarm_style_select &&
                (reg_read || (settings.shutdown && !shut_q));
  end

  // A new event wins over a clear that falls in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      alarm <= 1'b0;
      want_release <= 1'b0;
      fault_cnt <= 3'h0;
      shut_q <= 1'b0;
    end else begin
      shut_q <= settings.shutdown;
      if (conv_done) begin
        if (!fault || event_hit) begin
          fault_cnt <= 3'h0;
        end else begin
          fault_cnt <= fault_cnt + 3'h1;
        end
      end
      if (event_hit) begin
        want_release <= !want_release;
        if (settings.alarm_style_select) alarm <= 1'b1;
        else alarm <= !want_release;
      end else if (clear_hit) begin
        alarm <= 1'b0;
      end
    end
  end

  // Open-drain alarm: drive low when the pin level should be low.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      alarm_oe <= 1'b0;
    end else begin
      alarm_oe <= alarm ^ settings.alarm_polarity;
    end
  end

  assign alarm_output = 1'b0;
endmodule : tma_monitor
`default_nettype wire

// >>> tb/tma_monitor_props.sv
`timescale 1ns/10ps
`default_nettype none
module tma_monitor_props #(
  parameter int CONV_CYC = 200,
  parameter int STUCK_CYC = 500
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Converter and alarm
  input wire logic converter_busy,
  input wire logic alarm_output,
  input wire logic alarm_oe
);
  int busy_cnt;
  int low_cnt;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  always_ff @(posedge sys_clk) begin
    if (rst || !converter_busy) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst || sda_in) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end
  a_busy_length: assert property ($fell(converter_busy) |->
    busy_cnt == CONV_CYC) else $error("busy length wrong");
  a_busy_bound: assert property (busy_cnt <= CONV_CYC)
    else $error("busy too long");
  a_start_reset: assert property ($fell(rst) |-> ##[0:3] converter_busy)
    else $error("no conversion after reset");
  a_alarm_reset: assert property ($fell(rst) |-> !alarm_oe [*3])
    else $error("alarm active after reset");
  a_bus_reset: assert property ($fell(rst) |-> !sda_oe [*3])
    else $error("data line driven after reset");
  a_drive_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data changed while clock high");
  a_stuck_release: assert property (low_cnt >= STUCK_CYC + 16 |->
    !sda_oe) else $error("data line not released");
  a_open_drain: assert property (!sda_out && !alarm_output)
    else $error("open drain value not low");
  c_conv_end: cover property ($fell(converter_busy));
  c_alarm_on: cover property ($rose(alarm_oe));
  c_stuck: cover property (low_cnt == STUCK_CYC);
endmodule : tma_monitor_props
bind tma_monitor tma_monitor_props #(
  .CONV_CYC(CONV_CYC),
  .STUCK_CYC(STUCK_CYC)
) i_props (
  .sys_clk(sys_clk),
  .rst(rst),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .converter_busy(converter_busy),
  .alarm_output(alarm_output),
  .alarm_oe(alarm_oe)
);
`default_nettype wire

// >>> tb/tma_master.sv
`timescale 1ns/10ps
`default_nettype none
// Bus master model; the clock idles high between frames.
module tma_master (
  // Clock
  input wire logic sys_clk,
  // Bus
  input wire logic sda_bus,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q();
    repeat (4) @(negedge sys_clk);
  endtask : q
  task automatic start();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
    q();
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    q();
    scl = 1'b1;
    q();
    r = sda_bus;
    q();
    scl = 1'b0;
    q();
  endtask : bit_io
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask : rbyte
endmodule : tma_master
`default_nettype wire

// >>> tb/tma_monitor_bench.sv
`timescale 1ns/10ps
`default_nettype none
module tma_monitor_bench;
  import tma_pkg::*;
  localparam int P = 2000;
  localparam int C = 200;
  localparam int S = 500;
  // Samples of 81, just 80 after truncation, and 74 degrees.
  localparam logic [10:0] HOT = 11'h288;
  localparam logic [10:0] EDGE = 11'h283;
  localparam logic [10:0] COLD = 11'h250;
  logic sys_clk, rst, scl, sda_low, sda_bus, sda_out, sda_oe;
  logic converter_busy, alarm_output, alarm_oe;
  logic [2:0] straps;
  logic [10:0] sample;
  int failures, n_tests;
  assign sda_bus = !(sda_low || sda_oe);
  tma_master i_m (.sys_clk(sys_clk), .sda_bus(sda_bus), .scl(scl),
    .sda_low(sda_low));
  tma_monitor #(.PERIOD_CYC(P), .CONV_CYC(C), .STUCK_CYC(S)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda_bus),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_hi(straps[2]),
    .addr_strap_mid(straps[1]), .addr_strap_lo(straps[0]),
    .sensor_sample(sample), .converter_busy(converter_busy),
    .alarm_output(alarm_output), .alarm_oe(alarm_oe));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  task automatic chk_al(input logic e);
    check("alarm", {15'h0000, alarm_oe}, {15'h0000, e});
  endtask : chk_al
  task automatic reg_wr(input logic [7:0] sel, input logic [15:0] d,
      input logic two);
    logic a;
    i_m.start();
    i_m.wbyte({TMA_ADDR_FIXED, straps, 1'b0}, a);
    i_m.wbyte(sel, a);
    i_m.wbyte(d[15:8], a);
    if (two) begin
      i_m.wbyte(d[7:0], a);
    end
    i_m.stop();
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] sel, output logic [15:0] d);
    logic a;
    i_m.start();
    i_m.wbyte({TMA_ADDR_FIXED, straps, 1'b0}, a);
    i_m.wbyte(sel, a);
    i_m.start();
    i_m.wbyte({TMA_ADDR_FIXED, straps, 1'b1}, a);
    i_m.rbyte(1'b0, d[15:8]);
    i_m.rbyte(1'b1, d[7:0]);
    i_m.stop();
  endtask : reg_rd
  task automatic rd_chk(input logic [7:0] sel, input logic [15:0] e,
      input string what);
    logic [15:0] d;
    reg_rd(sel, d);
    check(what, d, e);
  endtask : rd_chk
  task automatic wait_conv();
    int k;
    for (k = 0; !converter_busy && k < 3 * P; k++) tick(1);
    if (k == 3 * P) failures++;
    for (k = 0; converter_busy && k < 3 * P; k++) tick(1);
    if (k == 3 * P) failures++;
    tick(3);
  endtask : wait_conv
  task automatic busy_seen(input int n, output logic s);
    s = 1'b0;
    repeat (n) begin
      tick(1);
      s = s | converter_busy;
    end
  endtask : busy_seen
  task automatic t_address();
    logic a;
    for (int k = 0; k < 2; k++) begin
      straps = k ? 3'b010 : 3'b101;
      i_m.start();
      i_m.wbyte({TMA_ADDR_FIXED, straps, 1'b0}, a);
      i_m.stop();
      check("ack own", {15'h0000, a}, 16'h0001);
      i_m.start();
      i_m.wbyte({TMA_ADDR_FIXED, ~straps, 1'b0}, a);
      i_m.stop();
      check("ack other", {15'h0000, a}, 16'h0000);
    end
  endtask : t_address
  task automatic t_defaults();
    logic a;
    logic [15:0] d;
    rd_chk(8'h01, 16'h0000, "settings");
    rd_chk(8'h02, 16'h4B00, "release");
    rd_chk(8'h03, 16'h5000, "trip");
    wait_conv();
    rd_chk(8'h00, {COLD, 5'h00}, "result");
    reg_wr(8'h00, 16'h1234, 1'b1);
    rd_chk(8'h00, {COLD, 5'h00}, "result ro");
    reg_wr(8'h03, 16'h7F80, 1'b1);
    rd_chk(8'h03, 16'h7F80, "trip rw");
    // A read with no select byte reuses the latched selection.
    i_m.start();
    i_m.wbyte({TMA_ADDR_FIXED, straps, 1'b1}, a);
    i_m.rbyte(1'b0, d[15:8]);
    i_m.rbyte(1'b1, d[7:0]);
    i_m.stop();
    check("latched select", d, 16'h7F80);
    reg_wr(8'h03, 16'h5000, 1'b1);
  endtask : t_defaults
  task automatic t_period();
    int n, m;
    for (n = 0; !converter_busy && n < P; n++) tick(1);
    for (n = 0; converter_busy && n < P; n++) tick(1);
    check("busy cycles", n[15:0], C[15:0]);
    for (m = n; !converter_busy && m < 2 * P; m++) tick(1);
    check("period", m[15:0], P[15:0]);
  endtask : t_period
  task automatic t_compare();
    logic [15:0] d;
    logic s;
    sample = EDGE;
    wait_conv();
    chk_al(1'b0);
    sample = HOT;
    wait_conv();
    chk_al(1'b1);
    reg_rd(8'h00, d);
    chk_al(1'b1);
    reg_wr(8'h01, 16'h0100, 1'b0);
    tick(C);
    chk_al(1'b1);
    busy_seen(P + 100, s);
    check("shutdown busy", {15'h0000, s}, 16'h0000);
    rd_chk(8'h00, {HOT, 5'h00}, "held result");
    sample = COLD;
    reg_wr(8'h01, 16'h0000, 1'b0);
    busy_seen(64, s);
    check("restart", {15'h0000, s}, 16'h0001);
    wait_conv();
    chk_al(1'b0);
    reg_wr(8'h01, 16'h0400, 1'b0);
    chk_al(1'b1);
    sample = HOT;
    wait_conv();
    chk_al(1'b0);
    reg_wr(8'h01, 16'h0000, 1'b0);
    sample = COLD;
    wait_conv();
  endtask : t_compare
  task automatic t_queue();
    int codes[4] = '{1, 2, 4, 6};
    int n;
    for (int k = 0; k < 4; k++) begin
      reg_wr(8'h01, {3'b000, k[1:0], 11'h000}, 1'b0);
      sample = HOT;
      n = 0;
      do begin
        wait_conv();
        n++;
      end while (!alarm_oe && n < 8);
      check("fault count", n[15:0], codes[k][15:0]);
      reg_wr(8'h01, 16'h0000, 1'b0);
      sample = COLD;
      wait_conv();
      chk_al(1'b0);
    end
  endtask : t_queue
  task automatic t_interrupt();
    logic [15:0] d;
    reg_wr(8'h01, 16'h0200, 1'b0);
    sample = HOT;
    wait_conv();
    wait_conv();
    chk_al(1'b1);
    rd_chk(8'h01, 16'h0200, "style");
    chk_al(1'b0);
    wait_conv();
    chk_al(1'b0);
    sample = COLD;
    wait_conv();
    chk_al(1'b1);
    reg_rd(8'h00, d);
    chk_al(1'b0);
    sample = HOT;
    wait_conv();
    chk_al(1'b1);
    reg_wr(8'h01, 16'h0300, 1'b0);
    chk_al(1'b0);
    reg_wr(8'h01, 16'h0000, 1'b0);
    sample = COLD;
  endtask : t_interrupt
  task automatic t_stuck();
    logic [7:0] adr;
    logic r;
    adr = {TMA_ADDR_FIXED, straps, 1'b1};
    i_m.start();
    for (int i = 7; i >= 0; i--) i_m.bit_io(adr[i], r);
    i_m.sda_low = 1'b0;
    i_m.q();
    i_m.scl = 1'b1;
    tick(S + 40);
    check("stuck release", {15'h0000, sda_oe}, 16'h0000);
    i_m.scl = 1'b0;
    i_m.q();
    i_m.stop();
    rd_chk(8'h02, 16'h4B00, "after stuck");
  endtask : t_stuck
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  // The tests need about 70,000 cycles; give up after 95,000.
  initial begin
    #950_000;
    failures++;
    print_verdict();
  end
  initial begin
    failures = 0;
    n_tests = 0;
    rst = 1'b1;
    straps = 3'b101;
    sample = COLD;
    tick(5);
    rst = 1'b0;
    tick(3);
    t_address();
    t_defaults();
    t_period();
    t_compare();
    t_queue();
    t_interrupt();
    t_stuck();
    print_verdict();
  end
endmodule : tma_monitor_bench
`default_nettype wire
